// [hw/cmpc_filt_if.sv]
`timescale 1ns/1ps

interface cmpc_filt_if;
  logic       sample_en;
  logic       din;
  logic [2:0] count;
  logic       dout;

  modport ctrl (output sample_en, output din, output count, input dout);
  modport filt (input sample_en, input din, input count, output dout);
endinterface : cmpc_filt_if

// [hw/cmpc_filter.sv]
`timescale 1ns/1ps
`include "cmpc_regs.svh"

module cmpc_filter (
  input  wire logic  ref_clk_in,
  input  wire logic  rst_in,
  cmpc_filt_if.filt  f
);

  cmpc_pkg::cmpc_filt_s st;
  cmpc_pkg::cmpc_filt_s next_st;
  logic [3:0]           run_inc;

  // ----------------------------------------
  // Run counter of disagreeing samples
  // ----------------------------------------
  always_comb begin
    next_st = st;
    run_inc = {1'b0, st.run} + `CMPC_RUN_STEP;
    if (f.sample_en) begin
      if (f.din == st.out) begin
        next_st.run = `CMPC_CNT_OFF;
      end else if (run_inc >= {1'b0, f.count}) begin
        next_st.out = f.din;
        next_st.run = `CMPC_CNT_OFF;
      end else begin
        next_st.run = run_inc[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.dout = st.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_FILT_AGREE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (f.sample_en && f.din == st.out) |=> (st.run == `CMPC_CNT_OFF && $stable(st.out)))
    else $error("Agreeing sample did not clear the run count");

  AST_FILT_ONE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (f.sample_en && f.count == `CMPC_CNT_ONE) |=> (st.out == $past(f.din)))
    else $error("Count of one did not take the sample");

  AST_FILT_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !f.sample_en |=> $stable(st.out))
    else $error("Filter output moved without a sample");

endmodule : cmpc_filter

// [hw/cmpc_pkg.sv]
package cmpc_pkg;

  // ----------------------------------------
  // Register block state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] hyst;
    logic [7:0] cr1;
    logic [7:0] rdata;
    logic       samp_prev;
    logic [7:0] div_cnt;
    logic       windowed;
    logic       trig_armed;
  } cmpc_state_s;

  // ----------------------------------------
  // Filter state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] run;
    logic       out;
  } cmpc_filt_s;

endpackage : cmpc_pkg

// [hw/cmpc_regs.svh]
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CMPC_ADDR_CR0      8'h00
`define CMPC_ADDR_CR1      8'h01
`define CMPC_ADDR_STAT     8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMPC_RST_BYTE      8'h00
`define CMPC_RST_CNT       3'h0
`define CMPC_RST_HYST      2'h0

// ----------------------------------------
// First control register fields
// ----------------------------------------
`define CMPC_CR0_CNT_HI    6
`define CMPC_CR0_CNT_LO    4
`define CMPC_CR0_HYST_HI   1
`define CMPC_CR0_HYST_LO   0
`define CMPC_CR0_RSVD      8'h8C

// ----------------------------------------
// Second control register bits
// ----------------------------------------
`define CMPC_CR1_SAMPLE    7
`define CMPC_CR1_WINDOW    6
`define CMPC_CR1_TRIG      5
`define CMPC_CR1_SPEED     4
`define CMPC_CR1_INVERT    3
`define CMPC_CR1_OSEL      2
`define CMPC_CR1_PIN       1
`define CMPC_CR1_ENABLE    0

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define CMPC_STAT_FILT     0
`define CMPC_STAT_WIND     1
`define CMPC_STAT_STBY     2

// ----------------------------------------
// Filter constants
// ----------------------------------------
`define CMPC_CNT_OFF       3'h0
`define CMPC_CNT_ONE       3'h1
`define CMPC_RUN_STEP      4'h1

`endif

// [hw/cmpc_top.sv]
// What this block does
// - Bits 7, 3 and 2 of the first control register read as zero and ignore writes.
// - Bits 6 to 4 of the first register set how many agreeing samples change the filter.
// - A zero count with sampling mode forces the filtered output low.
// - A zero count without sampling mode bypasses the filter with the windowed output.
// - Counts 1 to 7 need exactly that many consecutive agreeing samples.
// - Bits 1 to 0 of the first register select one of four hysteresis levels.
// - Bit 7 of the second register selects sampling mode.
// - Bit 6 of the second register selects windowing mode.
// - Bit 5 of the second register places comparator and reference into trigger mode.
// - All eight bits of the second register are read-write and reset to zero.
// - In trigger mode comparator and reference stand by until a timer trigger arrives.
// - Sampling mode clocks the filter from the sample input, else from the divided clock.
// - Windowing mode samples the comparator each clock while the window input is high.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "cmpc_regs.svh"

module cmpc_top #(
  parameter logic [7:0] SAMPLE_DIV = 8'h01
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       cmp_raw_in,
  input  wire logic       window_in,
  input  wire logic       sample_in,
  input  wire logic       trigger_in,
  output logic      [1:0] hysteresis_level_select_out,
  output logic            speed_power_select_out,
  output logic            cmp_enable_out,
  output logic            triggered_compare_enable_out,
  output logic            compare_standby_out,
  output logic            windowed_compare_out,
  output logic            filtered_compare_out,
  output logic            selected_compare_out,
  output logic            output_pin_enable_out
);

  cmpc_pkg::cmpc_state_s st;
  cmpc_pkg::cmpc_state_s next_st;

  cmpc_filt_if filt_bus ();

  logic sampling_mode_enable;
  logic window_mode_enable;
  logic trig_mode;
  logic output_polarity_invert;
  logic div_tick;
  logic samp_edge;
  logic sample_en;
  logic raw_pol;
  logic filt_out;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign sampling_mode_enable   = st.cr1[`CMPC_CR1_SAMPLE];
  assign window_mode_enable     = st.cr1[`CMPC_CR1_WINDOW];
  assign trig_mode              = st.cr1[`CMPC_CR1_TRIG];
  assign output_polarity_invert = st.cr1[`CMPC_CR1_INVERT];

  // ----------------------------------------
  // Sampling clock enables
  // ----------------------------------------
  assign div_tick  = (st.div_cnt == SAMPLE_DIV - 8'h01);
  assign samp_edge = sample_in && !st.samp_prev;
  assign raw_pol   = cmp_raw_in ^ output_polarity_invert;

  // Trigger mode only lets a sample through once armed by the timer
  assign sample_en = (sampling_mode_enable ? samp_edge : div_tick)
                     && (!trig_mode || st.trig_armed);

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  assign filt_bus.sample_en = sample_en;
  assign filt_bus.din       = st.windowed;
  assign filt_bus.count     = st.cnt;
  assign filt_out           = filt_bus.dout;

  cmpc_filter u_filter (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .f          (filt_bus.filt)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_st.rdata = `CMPC_RST_BYTE;

    // Divider runs free so the filter rate does not depend on bus traffic
    if (div_tick) begin
      next_st.div_cnt = `CMPC_RST_BYTE;
    end else begin
      next_st.div_cnt = st.div_cnt + 8'h01;
    end
    next_st.samp_prev = sample_in;

    // Window gate holds its last value while the window is closed
    if (!window_mode_enable || window_in) begin
      next_st.windowed = raw_pol;
    end

    // Trigger set wins over the clear of a finished compare
    if (!trig_mode) begin
      next_st.trig_armed = 1'b0;
    end else if (trigger_in) begin
      next_st.trig_armed = 1'b1;
    end else if (sample_en) begin
      next_st.trig_armed = 1'b0;
    end

    if (wr_in) begin
      case (addr_in)
        `CMPC_ADDR_CR0: begin
          next_st.cnt  = wr_data_in[`CMPC_CR0_CNT_HI:`CMPC_CR0_CNT_LO];
          next_st.hyst = wr_data_in[`CMPC_CR0_HYST_HI:`CMPC_CR0_HYST_LO];
        end
        `CMPC_ADDR_CR1: begin
          next_st.cr1 = wr_data_in;
        end
        default: begin
          next_st.cr1 = st.cr1;
        end
      endcase
    end

    if (rd_in) begin
      case (addr_in)
        `CMPC_ADDR_CR0: begin
          next_st.rdata[`CMPC_CR0_CNT_HI:`CMPC_CR0_CNT_LO]   = st.cnt;
          next_st.rdata[`CMPC_CR0_HYST_HI:`CMPC_CR0_HYST_LO] = st.hyst;
        end
        `CMPC_ADDR_CR1: begin
          next_st.rdata = st.cr1;
        end
        `CMPC_ADDR_STAT: begin
          next_st.rdata[`CMPC_STAT_FILT] = filtered_compare_out;
          next_st.rdata[`CMPC_STAT_WIND] = st.windowed;
          next_st.rdata[`CMPC_STAT_STBY] = compare_standby_out;
        end
        default: begin
          next_st.rdata = `CMPC_RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    if (st.cnt == `CMPC_CNT_OFF) begin
      if (sampling_mode_enable) begin
        filtered_compare_out = 1'b0;
      end else begin
        filtered_compare_out = st.windowed;
      end
    end else begin
      filtered_compare_out = filt_out;
    end
  end

  assign selected_compare_out         = st.cr1[`CMPC_CR1_OSEL] ? st.windowed
                                                                : filtered_compare_out;
  assign rd_data_out                  = st.rdata;
  assign hysteresis_level_select_out  = st.hyst;
  assign speed_power_select_out       = st.cr1[`CMPC_CR1_SPEED];
  assign cmp_enable_out               = st.cr1[`CMPC_CR1_ENABLE];
  assign triggered_compare_enable_out = trig_mode;
  assign compare_standby_out          = trig_mode && !st.trig_armed;
  assign windowed_compare_out         = st.windowed;
  assign output_pin_enable_out        = st.cr1[`CMPC_CR1_PIN];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_RSVD_ZERO: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_in && addr_in == `CMPC_ADDR_CR0) |=>
      ((rd_data_out & `CMPC_CR0_RSVD) == `CMPC_RST_BYTE))
    else $error("Reserved bits of first control register read non-zero");

  AST_CNT_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR0) |=>
      (st.cnt == $past(wr_data_in[`CMPC_CR0_CNT_HI:`CMPC_CR0_CNT_LO])))
    else $error("Sample count field not written");

  AST_FORCE_LOW: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (st.cnt == `CMPC_CNT_OFF && sampling_mode_enable) |-> !filtered_compare_out)
    else $error("Zero count in sampling mode did not force output low");

  AST_BYPASS: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (st.cnt == `CMPC_CNT_OFF && !sampling_mode_enable) |->
      (filtered_compare_out == windowed_compare_out))
    else $error("Zero count without sampling did not bypass");

  AST_HYST_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR0) |=>
      (hysteresis_level_select_out == $past(wr_data_in[`CMPC_CR0_HYST_HI:`CMPC_CR0_HYST_LO])))
    else $error("Hysteresis field not written");

  AST_CR1_RW: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR1) ##1 (rd_in && addr_in == `CMPC_ADDR_CR1) |=>
      (rd_data_out == $past(wr_data_in, 2)))
    else $error("Second control register did not read back");

  AST_WIN_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (window_mode_enable && !window_in) |=> $stable(windowed_compare_out))
    else $error("Windowed output moved while window closed");

  AST_WIN_TAKE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (window_mode_enable && window_in) |=> (windowed_compare_out == $past(raw_pol)))
    else $error("Windowed output missed a sample");

  AST_STANDBY: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (trig_mode && !trigger_in && compare_standby_out) |=> (!trig_mode || !sample_en))
    else $error("Sample taken in standby");

  AST_SAMPLE_SRC: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (sampling_mode_enable && !(sample_in && !st.samp_prev)) |-> !sample_en)
    else $error("Sampling mode used a clock other than the sample input");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------

  AST_CR0_READ: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_in && addr_in == `CMPC_ADDR_CR0) |=>
      (rd_data_out == {1'h0, $past(st.cnt), 2'h0, $past(st.hyst)}))
    else $error("First control register read wrong fields");

  AST_CR0_KEEP: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !(wr_in && addr_in == `CMPC_ADDR_CR0) |=>
      ($stable(st.cnt) && $stable(st.hyst)))
    else $error("First control register changed without a write");

  AST_CR1_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR1) |=>
      (st.cr1 == $past(wr_data_in)))
    else $error("Second control register write lost");

  AST_CR1_READ: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_in && addr_in == `CMPC_ADDR_CR1) |=>
      (rd_data_out == $past(st.cr1)))
    else $error("Second control register read wrong value");

  AST_CR1_KEEP: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !(wr_in && addr_in == `CMPC_ADDR_CR1) |=>
      $stable(st.cr1))
    else $error("Second control register changed without a write");

  AST_RST_REGS: assert property (
    @(posedge ref_clk_in)
    rst_in |=> (st.cr1 == `CMPC_RST_BYTE && st.cnt == `CMPC_RST_CNT &&
                st.hyst == `CMPC_RST_HYST))
    else $error("Control registers did not reset to zero");

  AST_RST_FILT: assert property (
    @(posedge ref_clk_in)
    rst_in |=>
      (!filt_out && !windowed_compare_out && !filtered_compare_out))
    else $error("Filter state did not clear on reset");

  // ----------------------------------------
  // Mode checks
  // ----------------------------------------

  AST_TRIG_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR1) |=>
      (triggered_compare_enable_out == $past(wr_data_in[`CMPC_CR1_TRIG])))
    else $error("Trigger mode bit not applied");

  AST_SAMP_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR1) |=>
      (sampling_mode_enable == $past(wr_data_in[`CMPC_CR1_SAMPLE])))
    else $error("Sampling mode bit not applied");

  AST_WIN_WRITE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_in && addr_in == `CMPC_ADDR_CR1) |=>
      (window_mode_enable == $past(wr_data_in[`CMPC_CR1_WINDOW])))
    else $error("Windowing mode bit not applied");

  AST_WIN_OFF: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !window_mode_enable |=>
      (windowed_compare_out == $past(raw_pol)))
    else $error("Window gate not bypassed outside windowing mode");

  AST_ARM: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (trig_mode && trigger_in) |=>
      !compare_standby_out)
    else $error("Timer trigger did not leave standby");

  AST_STBY_STAY: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (compare_standby_out && !trigger_in) |=>
      (compare_standby_out || !trig_mode))
    else $error("Standby left without a trigger");

  AST_DIV_SRC: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (!sampling_mode_enable && !trig_mode) |->
      (sample_en == div_tick))
    else $error("Divided clock not used as sampling clock");

  AST_SAMP_EDGE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (sampling_mode_enable && !trig_mode && $rose(sample_in)) |->
      sample_en)
    else $error("Sample input edge did not sample");

endmodule : cmpc_top

// [tb/cmpc_top_test.sv]
`timescale 1ns/1ps

module cmpc_top_test;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic       ref_clk_in  = 1'b0;
  logic       rst_in      = 1'b1;
  logic [7:0] addr_in     = 8'h00;
  logic [7:0] wr_data_in  = 8'h00;
  logic       wr_in       = 1'b0;
  logic       rd_in       = 1'b0;
  logic       cmp_raw_in  = 1'b0;
  logic       window_in   = 1'b0;
  logic       sample_in   = 1'b0;
  logic       trigger_in  = 1'b0;
  logic [7:0] rd_data_out;
  logic [1:0] hyst;
  logic       speed;
  logic       en;
  logic       trig;
  logic       stby;
  logic       wind;
  logic       filt;
  logic       sel;
  logic       pin;
  logic [7:0] v;
  int         num_errors  = 0;
  int         total_checks = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  cmpc_top #(.SAMPLE_DIV(8'h01)) dut (
    .ref_clk_in                   (ref_clk_in),
    .rst_in                       (rst_in),
    .addr_in                      (addr_in),
    .wr_data_in                   (wr_data_in),
    .wr_in                        (wr_in),
    .rd_in                        (rd_in),
    .rd_data_out                  (rd_data_out),
    .cmp_raw_in                   (cmp_raw_in),
    .window_in                    (window_in),
    .sample_in                    (sample_in),
    .trigger_in                   (trigger_in),
    .hysteresis_level_select_out  (hyst),
    .speed_power_select_out       (speed),
    .cmp_enable_out               (en),
    .triggered_compare_enable_out (trig),
    .compare_standby_out          (stby),
    .windowed_compare_out         (wind),
    .filtered_compare_out         (filt),
    .selected_compare_out         (sel),
    .output_pin_enable_out        (pin)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge ref_clk_in);
    wr_in      <= 1'b0;
    #1;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rd_data_out;
  endtask : rd

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge ref_clk_in);
    wr_in      <= 1'b0;
    rd_in      <= 1'b1;
    @(posedge ref_clk_in);
    rd_in      <= 1'b0;
    #1;
    q = rd_data_out;
  endtask : wr_rd

  task automatic raw(input logic b);
    @(posedge ref_clk_in);
    cmp_raw_in <= b;
  endtask : raw

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    rd(8'h00, v); chk(v, 8'h00);
    rd(8'h01, v); chk(v, 8'h00);
    chk({7'h00, filt}, 8'h00);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, v); chk(v, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, v); chk(v, 8'h73);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h8C | 8'(i));
      chk({6'h00, hyst}, 8'(i));
    end
    wr_rd(8'h01, 8'hA5, v);
    chk(v, 8'hA5);
    chk({4'h0, trig, speed, pin, en}, 8'h09);
    wr(8'h01, 8'h5A);
    rd(8'h01, v); chk(v, 8'h5A);
    chk({4'h0, trig, speed, pin, en}, 8'h06);
    $display("test_regs done");
  endtask : test_regs

  // Output must flip exactly on the Nth differing sample
  task automatic test_counts();
    wr(8'h01, 8'h00);
    for (int n = 1; n < 8; n++) begin
      wr(8'h00, {1'b0, 3'(n), 4'h0});
      raw(1'b0);
      tick(12);
      raw(1'b1);
      tick(n);
      chk({7'h00, filt}, 8'h00);
      tick(1);
      chk({7'h00, filt}, 8'h01);
    end
    raw(1'b0);
    tick(12);
    chk({7'h00, filt}, 8'h00);
    wr(8'h00, 8'h30);
    raw(1'b1);
    tick(1);
    raw(1'b0);
    tick(6);
    chk({7'h00, filt}, 8'h00);
    $display("test_counts done");
  endtask : test_counts

  task automatic test_bypass();
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    raw(1'b1);
    tick(1);
    chk({6'h00, wind, filt}, 8'h03);
    wr(8'h01, 8'h08);
    tick(1);
    chk({6'h00, wind, filt}, 8'h00);
    wr(8'h01, 8'h04);
    tick(1);
    chk({7'h00, sel}, 8'h01);
    wr(8'h01, 8'h80);
    chk({7'h00, filt}, 8'h00);
    $display("test_bypass done");
  endtask : test_bypass

  task automatic test_window();
    wr(8'h01, 8'h40);
    @(posedge ref_clk_in);
    window_in  <= 1'b1;
    cmp_raw_in <= 1'b1;
    tick(2);
    chk({7'h00, wind}, 8'h01);
    @(posedge ref_clk_in);
    window_in  <= 1'b0;
    cmp_raw_in <= 1'b0;
    tick(4);
    chk({7'h00, wind}, 8'h01);
    @(posedge ref_clk_in);
    window_in <= 1'b1;
    tick(2);
    chk({7'h00, wind}, 8'h00);
    $display("test_window done");
  endtask : test_window

  // External sample edges alone may move the filter
  task automatic test_sample();
    wr(8'h00, 8'h10);
    wr(8'h01, 8'h80);
    raw(1'b1);
    tick(6);
    chk({7'h00, filt}, 8'h00);
    @(posedge ref_clk_in);
    sample_in <= 1'b1;
    tick(1);
    chk({7'h00, filt}, 8'h01);
    @(posedge ref_clk_in);
    sample_in <= 1'b0;
    $display("test_sample done");
  endtask : test_sample

  task automatic test_trigger();
    wr(8'h01, 8'h21);
    chk({5'h00, trig, stby, en}, 8'h07);
    @(posedge ref_clk_in);
    trigger_in <= 1'b1;
    tick(1);
    chk({7'h00, stby}, 8'h00);
    @(posedge ref_clk_in);
    trigger_in <= 1'b0;
    tick(4);
    chk({7'h00, stby}, 8'h01);
    rd(8'h03, v);
    chk(v, 8'h07);
    $display("test_trigger done");
  endtask : test_trigger

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    test_regs();
    test_counts();
    test_bypass();
    test_window();
    test_sample();
    test_trigger();
    stop_test();
  end

  // Whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    num_errors++;
    stop_test();
  end
endmodule : cmpc_top_test
